// file: spisc_pkg.sv
/*
  Constants, field positions and state types shared by the SPI slave
  controller and its testbench.
  Assumes: included in compile order ahead of every module that imports it.
*/
package spisc_pkg;

  // ----------------------------------------------------------------
  // character and buffer shape
  // ----------------------------------------------------------------
  localparam int         CHAR_W      = 8;
  localparam int         FIFO_DEPTH  = 4;
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [2:0] BIT_FIRST   = 3'h0;

  // ----------------------------------------------------------------
  // mode selection and fixed byte values
  // ----------------------------------------------------------------
  localparam int         MODE_W      = 3;
  localparam logic [2:0] MODE_SPI    = 3'h2;
  localparam logic [7:0] PAD_BYTE    = 8'hFF;
  localparam logic [7:0] BUSY_TOKEN  = 8'hFF;
  localparam logic [7:0] LAST_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // link timing: fastest serial rate against the system clock
  // ----------------------------------------------------------------
  localparam int SCLK_MAX_KBPS  = 5000;
  localparam int CLK_KHZ        = 25000;
  localparam int SCLK_HALF_CYC  = (CLK_KHZ / (2 * SCLK_MAX_KBPS)) < 1 ? 1 :
                                  (CLK_KHZ / (2 * SCLK_MAX_KBPS));

  // ----------------------------------------------------------------
  // receive DMA count and snapshot state field
  // ----------------------------------------------------------------
  localparam int DMA_CNT_W      = 16;
  localparam int SNAP_W         = 3;
  localparam int SNAP_A_IDX     = 0;
  localparam int SNAP_B_IDX     = 1;
  localparam int SNAP_EXTRA_IDX = 2;
  localparam logic [2:0] SNAP_CLEAR = 3'h0;

  // gray along off -> idle -> frame
  typedef enum logic [1:0] {
    LINK_OFF   = 2'b00,
    LINK_IDLE  = 2'b01,
    LINK_FRAME = 2'b11
  } spisc_link_type;

endpackage

// file: spisc_sync.sv
/*
  Two flip-flop synchroniser for a bundle of asynchronous levels.
  Assumes: each bit is an independent level from outside the clk domain.
*/
`timescale 1ns/1ps
module spisc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= '1;
      sync_out <= '1;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// file: spisc_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides and an occupancy count.
  Assumes: one push and one pop per cycle at most; DEPTH of at least 2.
*/
`timescale 1ns/1ps
module spisc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // fill side
  input  wire logic                       in_valid,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            in_ready,
  // drain side
  output logic                            out_valid,
  output logic      [WIDTH-1:0]           out_data,
  input  wire logic                       out_ready,
  // occupancy
  output logic      [$clog2(DEPTH+1)-1:0] count
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] ptr);
    bump = (ptr == AW'(DEPTH - 1)) ? '0 : ptr + AW'(1);
  endfunction

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
  end

  // storage resets to zero; an early repeat sends the slave's last_tx, which resets to LAST_RESET (0x00)
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      if (push) begin
        mem[wr_ptr] <= in_data;
      end
    end
  end

endmodule

// file: spisc_slave.sv
/*
  SPI slave controller: serial link, four-entry transmit and receive
  FIFOs, padding and underrun bytes, status flags and receive DMA count
  snapshot on slave-select release.
  Assumes: SCLK, MOSI and slave select come straight from pins; the host
  side (software or DMA) drives the push/pop strobes on clk.
*/
// Operation
// R1: slave only when mode 2, master bit clear
// R2: external clock, at most 5 Mbps
// R3: polarity, phase, bit order set frame format
// R4: MISO carries data only while selected
// R5: select falling edge resets shift registers
// R6: MISO always driven, never tri-stated
// R7: separate four-entry transmit and receive FIFOs
// R8: data write pushes, data read pops
// R9: DMA uses same push and pop paths
// R10: received bytes stored; valid while nonempty
// R11: full receive FIFO drops byte, flags overflow
// R12: DMA error shown only after receive drain
// R13: DMA error cleared by reset or load
// R14: each received byte sends one byte
// R15: empty transmit FIFO flags underrun
// R16: underrun sends last byte or 0xFF
// R17: write into empty idle clears idle
// R18: space clears when full, sets on shift
// R19: idle sets when empty and shifted out
// R20: 0xFF padding byte first each select
// R21: first select release saves DMA count
// R22: later releases flagged in 3-bit field
// R23: repeat setting applies only when idle
// R24: data read clears overflow flag
// R25: phase picks leading or second sample edge
// R26: polarity picks rising or falling leading edge
// R27: 8-bit chars; pins synchronised first
`timescale 1ns/1ps
module spisc_slave
  import spisc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int CNT_W = DMA_CNT_W
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // serial pins
  input  wire logic              sclk_pin,
  input  wire logic              mosi_pin,
  input  wire logic              slave_select_n,
  output logic                   miso,
  output logic                   miso_oe,
  // configuration
  input  wire logic [MODE_W-1:0] serial_mode_reg,
  input  wire logic              master_select_bit,
  input  wire logic              clock_polarity_bit,
  input  wire logic              clock_phase_bit,
  input  wire logic              bit_order_bit,
  input  wire logic              repeat_last_bit,
  // data port: transmit push
  input  wire logic              tx_push,
  input  wire logic [CHAR_W-1:0] tx_push_data,
  output logic                   tx_push_ready,
  // data port: receive pop
  input  wire logic              rx_pop,
  output logic      [CHAR_W-1:0] rx_pop_data,
  // status
  output logic                   rx_valid_flag,
  output logic                   rx_overflow_flag,
  output logic                   tx_space_flag,
  output logic                   tx_idle_flag,
  output logic                   rx_overrun_irq,
  output logic                   tx_underrun_irq,
  // receive DMA
  input  wire logic              rx_dma_active,
  input  wire logic              rx_dma_buffer_b,
  input  wire logic [CNT_W-1:0]  rx_dma_count_a,
  input  wire logic [CNT_W-1:0]  rx_dma_count_b,
  input  wire logic              rx_dma_load,
  input  wire logic              dma_reset_bits,
  output logic      [CNT_W-1:0]  rx_count_snapshot,
  output logic      [SNAP_W-1:0] snapshot_state_field,
  output logic                   rx_dma_error
);

  localparam int CW = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [CHAR_W-1:0] shift_in(input logic [CHAR_W-1:0] r,
                                                 input logic b, input logic lsb);
    shift_in = lsb ? {b, r[CHAR_W-1:1]} : {r[CHAR_W-2:0], b};
  endfunction

  function automatic logic [CHAR_W-1:0] shift_out(input logic [CHAR_W-1:0] r,
                                                  input logic lsb);
    shift_out = lsb ? {1'b1, r[CHAR_W-1:1]} : {r[CHAR_W-2:0], 1'b1};
  endfunction

  function automatic logic out_bit(input logic [CHAR_W-1:0] r, input logic lsb);
    out_bit = lsb ? r[0] : r[CHAR_W-1];
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic sclk_s;
  logic mosi_s;
  logic ssn_s;
  logic sclk_d;
  logic ssn_d;

  spisc_sync #(.WIDTH(3)) u_sync ( // R2 R27
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({sclk_pin, mosi_pin, slave_select_n}),
    .sync_out ({sclk_s, mosi_s, ssn_s})
  );

  logic sclk_rise;
  logic sclk_fall;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic shift_edge;
  logic ssn_fall;
  logic ssn_rise;
  logic slave_en;

  assign sclk_rise   = sclk_s & ~sclk_d; // R27
  assign sclk_fall   = ~sclk_s & sclk_d;
  assign lead_edge   = clock_polarity_bit ? sclk_fall : sclk_rise; // R26
  assign trail_edge  = clock_polarity_bit ? sclk_rise : sclk_fall;
  assign sample_edge = clock_phase_bit ? trail_edge : lead_edge; // R25
  assign shift_edge  = clock_phase_bit ? lead_edge : trail_edge;
  assign ssn_fall    = ~ssn_s & ssn_d;
  assign ssn_rise    = ssn_s & ~ssn_d;
  assign slave_en    = (serial_mode_reg == MODE_SPI) && !master_select_bit; // R1

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  logic              tx_pop;
  logic              tx_avail;
  logic [CHAR_W-1:0] tx_head;
  logic [CW-1:0]     tx_count;
  logic              rx_push;
  logic              rx_in_ready;
  logic [CHAR_W-1:0] rx_byte;
  logic [CW-1:0]     rx_count;

  // software and DMA share these two paths
  spisc_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) u_tx_fifo ( // R7 R8 R9
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (tx_push),
    .in_data   (tx_push_data),
    .in_ready  (tx_push_ready),
    .out_valid (tx_avail),
    .out_data  (tx_head),
    .out_ready (tx_pop),
    .count     (tx_count)
  );

  spisc_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) u_rx_fifo ( // R7 R8 R9
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (rx_push),
    .in_data   (rx_byte),
    .in_ready  (rx_in_ready),
    .out_valid (rx_valid_flag),
    .out_data  (rx_pop_data),
    .out_ready (rx_pop),
    .count     (rx_count)
  );

  assign tx_space_flag = tx_push_ready; // R18
  assign miso_oe       = 1'b1; // R6

  // ----------------------------------------------------------------
  // serial link
  // ----------------------------------------------------------------
  spisc_link_type    state;
  spisc_link_type    next_state;
  logic [2:0]        bit_cnt;
  logic [2:0]        next_bit_cnt;
  logic [CHAR_W-1:0] rx_shift;
  logic [CHAR_W-1:0] next_rx_shift;
  logic [CHAR_W-1:0] tx_shift;
  logic [CHAR_W-1:0] next_tx_shift;
  logic [CHAR_W-1:0] last_tx;
  logic [CHAR_W-1:0] next_last_tx;
  logic              fresh;
  logic              next_fresh;
  logic              tx_busy;
  logic              next_tx_busy;
  logic              repeat_eff;
  logic              next_repeat_eff;
  logic              next_miso;
  logic              underrun;

  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_rx_shift   = rx_shift;
    next_tx_shift   = tx_shift;
    next_last_tx    = last_tx;
    next_fresh      = fresh;
    next_tx_busy    = tx_busy;
    next_repeat_eff = repeat_eff;
    tx_pop          = 1'b0;
    rx_push         = 1'b0;
    rx_byte         = shift_in(rx_shift, mosi_s, bit_order_bit); // R3
    underrun        = 1'b0;
    // repeat mode latched only with nothing queued or in flight
    if (!tx_avail && !tx_busy) begin
      next_repeat_eff = repeat_last_bit; // R23
    end
    case (state)
      LINK_OFF: begin
        if (slave_en) begin
          next_state = LINK_IDLE;
        end
      end
      LINK_IDLE: begin
        if (!slave_en) begin
          next_state = LINK_OFF;
        end else if (ssn_fall) begin
          next_state    = LINK_FRAME;
          next_bit_cnt  = BIT_FIRST; // R5
          next_rx_shift = '0; // R5
          next_tx_shift = PAD_BYTE; // R20
          next_fresh    = clock_phase_bit;
        end
      end
      LINK_FRAME: begin
        if (!slave_en) begin
          next_state = LINK_OFF;
        end else if (ssn_rise) begin
          next_state = LINK_IDLE;
        end else begin
          // a freshly loaded byte keeps its first bit for one shift edge
          if (shift_edge) begin
            if (fresh) begin
              next_fresh = 1'b0;
            end else begin
              next_tx_shift = shift_out(tx_shift, bit_order_bit); // R3
            end
          end
          if (sample_edge) begin
            next_rx_shift = rx_byte;
            next_bit_cnt  = bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST) begin
              rx_push    = 1'b1; // R10 R27
              next_fresh = 1'b1;
              if (tx_avail) begin
                tx_pop        = 1'b1; // R14
                next_tx_shift = tx_head;
                next_last_tx  = tx_head;
                next_tx_busy  = 1'b1;
              end else begin
                underrun      = 1'b1; // R15
                next_tx_busy  = 1'b0; // R19
                next_tx_shift = repeat_eff ? last_tx : BUSY_TOKEN; // R16
              end
            end
          end
        end
      end
      default: begin
        next_state = LINK_OFF;
      end
    endcase
    // idle level is high but the pin stays driven
    next_miso = (next_state == LINK_FRAME) ? out_bit(next_tx_shift, bit_order_bit)
                                            : 1'b1; // R4 R6
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= LINK_OFF;
      sclk_d     <= 1'b1;
      ssn_d      <= 1'b1;
      bit_cnt    <= BIT_FIRST;
      rx_shift   <= '0;
      tx_shift   <= PAD_BYTE;
      last_tx    <= LAST_RESET;
      fresh      <= 1'b0;
      tx_busy    <= 1'b0;
      repeat_eff <= 1'b0;
      miso       <= 1'b1;
    end else begin
      state      <= next_state;
      sclk_d     <= sclk_s;
      ssn_d      <= ssn_s;
      bit_cnt    <= next_bit_cnt;
      rx_shift   <= next_rx_shift;
      tx_shift   <= next_tx_shift;
      last_tx    <= next_last_tx;
      fresh      <= next_fresh;
      tx_busy    <= next_tx_busy;
      repeat_eff <= next_repeat_eff;
      miso       <= next_miso;
    end
  end

  // ----------------------------------------------------------------
  // status flags and event pulses
  // ----------------------------------------------------------------
  logic overrun;
  logic rx_read;
  logic next_rx_overflow_flag;
  logic next_tx_idle_flag;

  assign overrun = rx_push & ~rx_in_ready; // R11
  assign rx_read = rx_pop & rx_valid_flag;

  always_comb begin
    // a new overrun beats a simultaneous read
    next_rx_overflow_flag = overrun | (rx_overflow_flag & ~rx_read); // R11 R24
    next_tx_idle_flag     = !tx_avail && !tx_busy; // R17 R19
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_overflow_flag <= 1'b0;
      tx_idle_flag     <= 1'b1;
      rx_overrun_irq   <= 1'b0;
      tx_underrun_irq  <= 1'b0;
    end else begin
      rx_overflow_flag <= next_rx_overflow_flag;
      tx_idle_flag     <= next_tx_idle_flag;
      rx_overrun_irq   <= overrun; // R11
      tx_underrun_irq  <= underrun; // R15
    end
  end

  // ----------------------------------------------------------------
  // receive DMA error and count snapshot
  // ----------------------------------------------------------------
  logic              ovf_pending;
  logic              next_ovf_pending;
  logic              next_rx_dma_error;
  logic              snap_armed;
  logic              next_snap_armed;
  logic [CNT_W-1:0]  next_rx_count_snapshot;
  logic [SNAP_W-1:0] next_snapshot_state_field;
  logic              frame_end;

  assign frame_end = (state == LINK_FRAME) && ssn_rise;

  always_comb begin
    next_ovf_pending          = ovf_pending | (overrun & rx_dma_active);
    next_rx_dma_error         = rx_dma_error;
    next_snap_armed           = snap_armed;
    next_rx_count_snapshot    = rx_count_snapshot;
    next_snapshot_state_field = snapshot_state_field;
    if (rx_dma_load || dma_reset_bits) begin
      next_rx_dma_error = 1'b0; // R13
    end
    // held back until the receive FIFO has drained
    if (ovf_pending && rx_count == '0) begin
      next_ovf_pending  = 1'b0;
      next_rx_dma_error = 1'b1; // R12
    end
    if (rx_dma_load) begin
      next_snap_armed           = 1'b1;
      next_snapshot_state_field = SNAP_CLEAR;
    end
    if (frame_end && rx_dma_active) begin
      if (snap_armed) begin
        next_snap_armed        = rx_dma_load;
        next_rx_count_snapshot = rx_dma_buffer_b ? rx_dma_count_b : rx_dma_count_a; // R21
        next_snapshot_state_field[SNAP_A_IDX] = !rx_dma_buffer_b; // R22
        next_snapshot_state_field[SNAP_B_IDX] = rx_dma_buffer_b;
      end else begin
        next_snapshot_state_field[SNAP_EXTRA_IDX] = 1'b1; // R22
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_pending          <= 1'b0;
      rx_dma_error         <= 1'b0;
      snap_armed           <= 1'b0;
      rx_count_snapshot    <= '0;
      snapshot_state_field <= SNAP_CLEAR;
    end else begin
      ovf_pending          <= next_ovf_pending;
      rx_dma_error         <= next_rx_dma_error;
      snap_armed           <= next_snap_armed;
      rx_count_snapshot    <= next_rx_count_snapshot;
      snapshot_state_field <= next_snapshot_state_field;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_frame_open;
    state == LINK_IDLE && slave_en && ssn_fall;
  endsequence

  sequence s_byte_done;
    state == LINK_FRAME && slave_en && !ssn_rise && sample_edge && bit_cnt == BIT_LAST;
  endsequence

  a_pad_first: assert property (s_frame_open |=> tx_shift == PAD_BYTE && bit_cnt == BIT_FIRST) // R20
    else $error("padding byte not loaded at select");
  a_miso_driven: assert property (miso_oe) // R6
    else $error("miso released");
  a_slave_gate: assert property (!slave_en |=> state != LINK_FRAME) // R1
    else $error("frame active while not in slave mode");
  a_rx_stored: assert property (s_byte_done ##0 rx_in_ready |=> rx_count == $past(rx_count) + CW'(1) || $past(rx_read)) // R10
    else $error("received byte not stored");
  a_ovf_flag: assert property (overrun |=> rx_overflow_flag && rx_overrun_irq ##1 !rx_overrun_irq) // R11
    else $error("overflow not flagged");
  a_underrun_tok: assert property (s_byte_done ##0 !tx_avail && !repeat_eff |=> tx_underrun_irq && tx_shift == BUSY_TOKEN) // R15 R16
    else $error("underrun token wrong");
  a_space_full: assert property (tx_count == CW'(DEPTH) |-> !tx_space_flag) // R18
    else $error("space flag set while full");
  a_snap_once: assert property (frame_end && !snap_armed |=> $stable(rx_count_snapshot)) // R21
    else $error("snapshot overwritten");
  a_dma_err_wait: assert property (rx_dma_error && !$past(rx_dma_error) |-> $past(rx_count) == '0) // R12
    else $error("dma error raised before drain");
  a_idle_clear: assert property (tx_push && tx_push_ready && tx_idle_flag |=> ##1 !tx_idle_flag) // R17
    else $error("idle flag not cleared by write");

endmodule

// file: spisc_master_model.sv
/*
  Behavioural SPI master driving the slave pins in either clock phase.
  Assumes: the bench calls sel and xfer in frame order.
*/
`timescale 1ns/1ps
module spisc_master_model (
  // serial pins
  output logic      sclk_pin,
  output logic      mosi_pin,
  output logic      slave_select_n,
  input  wire logic miso,
  // frame format
  input  wire logic clock_polarity_bit,
  input  wire logic clock_phase_bit,
  input  wire logic bit_order_bit
);
  logic ph = 1'b0;

  // clock stands at its idle level outside frames
  assign sclk_pin = clock_polarity_bit ^ ph;
  initial begin
    mosi_pin = 1'b0;
    slave_select_n = 1'b1;
  end

  // odd offset keeps pin edges away from the sampling clock
  task automatic sel(input logic on);
    #407;
    slave_select_n = ~on;
    if (!on) begin
      mosi_pin = ~mosi_pin;
    end
    #400;
  endtask

  // read just before the sample edge: the slave reloads right after it
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    int b;
    for (int i = 0; i < 8; i++) begin
      b = bit_order_bit ? i : 7 - i;
      ph = clock_phase_bit;
      mosi_pin = tx[b];
      #155;
      rx[b] = miso;
      #5;
      ph = ~clock_phase_bit;
      #160;
    end
    ph = 1'b0;
  endtask
endmodule

// file: spisc_slave_tb.sv
/*
  Self-checking bench for the SPI slave controller.
  Assumes: the master model follows the bench's polarity, phase and order bits.
*/
`timescale 1ns/1ps
module spisc_slave_tb
  import spisc_pkg::*;
;
  logic              clk = 1'b0, reset_n = 1'b0, tx_push = 1'b0, rx_pop = 1'b0;
  logic              master_select_bit = 1'b0, clock_polarity_bit = 1'b0;
  logic              clock_phase_bit = 1'b0, bit_order_bit = 1'b0, repeat_last_bit = 1'b0;
  logic              rx_dma_active = 1'b0, rx_dma_buffer_b = 1'b0, rx_dma_load = 1'b0;
  logic              dma_reset_bits = 1'b0;
  logic [MODE_W-1:0] serial_mode_reg = 3'h2;
  logic [7:0]        tx_push_data = 8'h00;
  logic [15:0]       rx_dma_count_a = 16'h0123, rx_dma_count_b = 16'h0BAD;
  logic              sclk_pin, mosi_pin, slave_select_n, miso, miso_oe, tx_push_ready;
  logic              rx_valid_flag, rx_overflow_flag, tx_space_flag, tx_idle_flag;
  logic              rx_overrun_irq, tx_underrun_irq, rx_dma_error;
  logic [7:0]        rx_pop_data;
  logic [15:0]       rx_count_snapshot;
  logic [SNAP_W-1:0] snapshot_state_field;
  int                errors = 0, compares = 0, und_n = 0, ovr_n = 0;

  spisc_slave i_dut (
    .clk, .reset_n, .sclk_pin, .mosi_pin, .slave_select_n, .miso, .miso_oe,
    .serial_mode_reg, .master_select_bit, .clock_polarity_bit, .clock_phase_bit,
    .bit_order_bit, .repeat_last_bit, .tx_push, .tx_push_data, .tx_push_ready,
    .rx_pop, .rx_pop_data, .rx_valid_flag, .rx_overflow_flag, .tx_space_flag,
    .tx_idle_flag, .rx_overrun_irq, .tx_underrun_irq, .rx_dma_active,
    .rx_dma_buffer_b, .rx_dma_count_a, .rx_dma_count_b, .rx_dma_load,
    .dma_reset_bits, .rx_count_snapshot, .snapshot_state_field, .rx_dma_error
  );
  spisc_master_model i_master (
    .sclk_pin, .mosi_pin, .slave_select_n, .miso, .clock_polarity_bit,
    .clock_phase_bit, .bit_order_bit
  );

  initial begin
    forever #20 clk = ~clk;
  end
  // event pulses last one cycle, so tally them here
  always @(posedge clk) begin
    und_n <= und_n + int'(tx_underrun_irq === 1'b1);
    ovr_n <= ovr_n + int'(rx_overrun_irq === 1'b1);
  end

  // ----------------------------
  // access tasks
  // ----------------------------
  task automatic check(input string what, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // strobe mask, high bit first: tx_push, rx_pop, rx_dma_load, dma_reset_bits
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    {tx_push, rx_pop, rx_dma_load, dma_reset_bits} <= m;
    @(posedge clk);
    {tx_push, rx_pop, rx_dma_load, dma_reset_bits} <= 4'h0;
  endtask
  task automatic push(input logic [7:0] d);
    tx_push_data <= d;
    pulse(4'h8);
  endtask
  task automatic pop(input logic [7:0] exp);
    @(negedge clk);
    check("rx data", rx_pop_data, exp);
    pulse(4'h4);
  endtask
  task automatic frame(input logic [7:0] tx[$], input logic [7:0] exp[$]);
    logic [7:0] rx;
    i_master.sel(1'b1);
    foreach (tx[i]) begin
      i_master.xfer(tx[i], rx);
      check("miso byte", rx, exp[i]);
    end
    i_master.sel(1'b0);
  endtask
  task automatic end_of_test();
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------
  // scenarios
  // ----------------------------
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    check("idle", tx_idle_flag, 1'b1);
    check("miso", {miso_oe, miso}, 2'h3);
    rx_dma_active <= 1'b1;
    pulse(4'h2);
    for (int i = 1; i <= 5; i++) push(8'h11 * i);
    check("space", {tx_space_flag, tx_push_ready, tx_idle_flag}, 3'h0);
    frame('{8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5}, '{PAD_BYTE, 8'h11, 8'h22, 8'h33, 8'h44});
    check("flags", {rx_valid_flag, rx_overflow_flag, tx_space_flag, tx_idle_flag}, 4'hF);
    check("overrun", ovr_n, 16'h1);
    check("dma err early", rx_dma_error, 1'b0);
    rx_dma_count_a <= 16'h0456;
    for (int i = 0; i < 4; i++) pop(8'hA1 + 8'(i));
    repeat (2) @(posedge clk);
    check("drained", {rx_valid_flag, rx_overflow_flag, rx_dma_error}, 3'h1);
    pulse(4'h1);
    @(negedge clk);
    check("dma err clr", rx_dma_error, 1'b0);
    frame('{8'h00, 8'h00}, '{PAD_BYTE, BUSY_TOKEN});
    @(posedge clk);
    repeat_last_bit <= 1'b1;
    clock_polarity_bit <= 1'b1;
    clock_phase_bit <= 1'b1;
    bit_order_bit <= 1'b1;
    frame('{8'h5A, 8'hC3}, '{PAD_BYTE, 8'h44});
    check("underrun", und_n, 16'h5);
    check("snapshot", rx_count_snapshot, 16'h0123);
    check("snap state", snapshot_state_field, 3'h5);
    for (int i = 0; i < 4; i++) pop(i < 2 ? 8'h00 : (i == 2 ? 8'h5A : 8'hC3));
    serial_mode_reg <= 3'h3;
    frame('{8'h77}, '{8'hFF});
    check("disabled rx", rx_valid_flag, 1'b0);
    end_of_test();
  end
endmodule
